// ===== rtl/ethernet_general_control_pkg.sv
package ethernet_general_control_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int           ADDR_W      = 19;        // 512-KByte space
	localparam logic [18:0]  CTRL_OFFSET = 19'h00070; // control word
	localparam logic [5:0]   CTRL_RESET  = 6'h00;     // all engines off
	localparam logic [21:0]  UPPER_ZERO  = 22'h0;     // bits 31:10
	localparam logic [3:0]   MID_ZERO    = 4'h0;      // bits 9:6

	// field positions inside the control word
	localparam int BIT_RX_ENGINE  = 0;
	localparam int BIT_TX_ENGINE  = 1;
	localparam int BIT_RX_DMA     = 2;
	localparam int BIT_TX_DMA     = 3;
	localparam int BIT_RX_FP      = 4;
	localparam int BIT_TX_FP      = 5;
	localparam int BIT_SOFT_INT   = 8;

	// number of DMA request kinds: data, buffer desc, completion desc
	localparam int DMA_KINDS = 3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SPACE_CFG,
		SPACE_MEM,
		SPACE_IO
	} space_t;

	typedef struct packed {
		space_t              space;
		logic [ADDR_W-1:0]   addr;
		logic                write;
		logic [3:0]          byteEn;
		logic [31:0]         wdata;
	} host_req_t;

	// stored control bits, msb is bit 5 of the word
	typedef struct packed {
		logic txFrameProcessorOn;
		logic rxFrameProcessorOn;
		logic transmitDmaAllow;
		logic receiveDmaAllow;
		logic transmitEngineOn;
		logic receiveEngineOn;
	} ctrl_t;

endpackage

// ===== rtl/ethernet_general_control.sv
`timescale 1ns/1ps

module ethernet_general_control (
	input  wire logic                                      clk,              // transmit clock
	input  wire logic                                      rst,              // sync reset
	input  wire logic                                      hostReq,          // host request level
	input  wire ethernet_general_control_pkg::host_req_t   hostCmd,          // held while hostReq
	output logic                                           hostAck,          // ack level
	output logic [31:0]                                    hostRdata,        // read word
	input  wire logic                                      pciMasterError,   // dma-fatal error
	output logic                                           raiseSoftwareInterrupt, // to status word
	output ethernet_general_control_pkg::ctrl_t            ctrlState,        // stored bits
	output logic                                           txFrameProcessorRst, // hold tx fp
	output logic                                           rxFrameProcessorRst, // hold rx fp
	input  wire logic [ethernet_general_control_pkg::DMA_KINDS-1:0] txDmaReqIn, // raw tx req
	output logic [ethernet_general_control_pkg::DMA_KINDS-1:0]      txDmaReq,   // gated tx req
	input  wire logic [ethernet_general_control_pkg::DMA_KINDS-1:0] rxDmaReqIn, // raw rx req
	output logic [ethernet_general_control_pkg::DMA_KINDS-1:0]      rxDmaReq,   // gated rx req
	input  wire logic                                      txIndexWrIn,      // tx index write
	output logic                                           txIndexWr,        // permitted write
	input  wire logic                                      rxIndexWrIn,      // rx index write
	output logic                                           rxIndexWr,        // permitted write
	input  wire logic                                      txFrameValidIn,   // tx data valid
	output logic                                           txFrameValid,     // to network
	input  wire logic                                      rxFrameIn,        // high during frame
	output logic                                           rxFrameValid,     // accepted frame
	output logic                                           rxFrameDropped    // drop pulse
);

	// ------------------------------------------------------------
	// host access synchroniser and handshake
	// ------------------------------------------------------------
	typedef enum logic {
		ACC_IDLE,
		ACC_WAIT
	} acc_state_t;

	acc_state_t accState;
	acc_state_t next_accState;
	logic       reqSync1;
	logic       reqSync2;
	logic       next_hostAck;
	logic [31:0] next_hostRdata;
	logic       access;
	logic       ctrlHit;

	// two-flop catch of the host request level
	// hostCmd is taken as it stands: the host keeps it still while hostReq is up
	always_ff @(posedge clk) begin
		if (rst) begin
			reqSync1 <= 1'b0;
			reqSync2 <= 1'b0;
		end else begin
			reqSync1 <= hostReq;
			reqSync2 <= reqSync1;
		end
	end

	// offset decode is common to every space
	always_comb begin
		access  = (accState == ACC_IDLE) && reqSync2;
		ctrlHit = 1'b0;
		if (hostCmd.addr[18:2] == ethernet_general_control_pkg::CTRL_OFFSET[18:2]) begin
			ctrlHit = 1'b1;
		end else begin
			ctrlHit = 1'b0;
		end
	end

	// four-phase handshake with registered read data
	always_comb begin
		next_accState  = accState;
		next_hostAck   = hostAck;
		next_hostRdata = hostRdata;
		case (accState)
			ACC_IDLE: begin
				if (reqSync2) begin
					next_accState = ACC_WAIT;
					next_hostAck  = 1'b1;
					if (!hostCmd.write && ctrlHit) begin
						next_hostRdata = {ethernet_general_control_pkg::UPPER_ZERO,
							ethernet_general_control_pkg::MID_ZERO, ctrlState};
					end else if (!hostCmd.write) begin
						next_hostRdata = 32'h00000000;
					end
				end
			end
			ACC_WAIT: begin
				if (!reqSync2) begin
					next_accState = ACC_IDLE;
					next_hostAck  = 1'b0;
				end
			end
			default: begin
				next_accState = ACC_IDLE;
				next_hostAck  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			accState  <= ACC_IDLE;
			hostAck   <= 1'b0;
			hostRdata <= 32'h00000000;
		end else begin
			accState  <= next_accState;
			hostAck   <= next_hostAck;
			hostRdata <= next_hostRdata;
		end
	end

	// ------------------------------------------------------------
	// control word and software interrupt
	// ------------------------------------------------------------
	ethernet_general_control_pkg::ctrl_t next_ctrlState;
	logic                                next_raiseSoftwareInterrupt;
	logic                                ctrlWrite;

	// low byte holds the enables; bits 7:6 are accepted and dropped
	// a master error wins over a write to the dma enables in the same cycle
	always_comb begin
		ctrlWrite                   = access && hostCmd.write && ctrlHit;
		next_ctrlState              = ctrlState;
		next_raiseSoftwareInterrupt = 1'b0;
		if (ctrlWrite && hostCmd.byteEn[0]) begin
			next_ctrlState = hostCmd.wdata[5:0];
		end
		if (ctrlWrite && hostCmd.byteEn[1]) begin
			next_raiseSoftwareInterrupt =
				hostCmd.wdata[ethernet_general_control_pkg::BIT_SOFT_INT];
		end
		if (pciMasterError) begin
			next_ctrlState.transmitDmaAllow = 1'b0;
			next_ctrlState.receiveDmaAllow  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrlState              <= ethernet_general_control_pkg::CTRL_RESET;
			raiseSoftwareInterrupt <= 1'b0;
		end else begin
			ctrlState              <= next_ctrlState;
			raiseSoftwareInterrupt <= next_raiseSoftwareInterrupt;
		end
	end

	// ------------------------------------------------------------
	// gating of the engines, processors and DMA
	// ------------------------------------------------------------
	// processors are held in reset while their enable is clear
	always_comb begin
		txFrameProcessorRst = !ctrlState.txFrameProcessorOn;
		rxFrameProcessorRst = !ctrlState.rxFrameProcessorOn;
		txFrameValid = txFrameValidIn && ctrlState.transmitEngineOn;
		txIndexWr    = txIndexWrIn && !ctrlState.transmitDmaAllow;
		rxIndexWr    = rxIndexWrIn && !ctrlState.receiveDmaAllow;
	end

	// each request kind is gated by its direction's dma enable only
	// the engine enables never reach these gates
	genvar k;
	generate
		for (k = 0; k < ethernet_general_control_pkg::DMA_KINDS; k++) begin : gDma
			assign txDmaReq[k] = txDmaReqIn[k] && ctrlState.transmitDmaAllow;
			assign rxDmaReq[k] = rxDmaReqIn[k] && ctrlState.receiveDmaAllow;
		end
	endgenerate

	// ------------------------------------------------------------
	// receive frame admission
	// ------------------------------------------------------------
	logic rxFramePrev;
	logic rxPassing;
	logic next_rxPassing;
	logic next_rxFrameDropped;
	logic rxStart;

	// the decision is taken at frame start and kept to frame end,
	// so a frame already in flight is never cut in half
	always_comb begin
		rxStart             = rxFrameIn && !rxFramePrev;
		next_rxPassing      = rxPassing;
		next_rxFrameDropped = 1'b0;
		if (rxStart) begin
			next_rxPassing      = ctrlState.receiveEngineOn;
			next_rxFrameDropped = !ctrlState.receiveEngineOn;
		end else if (!rxFrameIn) begin
			next_rxPassing = 1'b0;
		end
		rxFrameValid = rxFrameIn && (rxStart ? ctrlState.receiveEngineOn : rxPassing);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rxFramePrev    <= 1'b0;
			rxPassing      <= 1'b0;
			rxFrameDropped <= 1'b0;
		end else begin
			rxFramePrev    <= rxFrameIn;
			rxPassing      <= next_rxPassing;
			rxFrameDropped <= next_rxFrameDropped;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence quietReq;
		$rose(hostReq) && !hostAck && !reqSync1 && !reqSync2 && accState == ACC_IDLE;
	endsequence

	sequence heldReq;
		quietReq ##1 hostReq ##1 hostReq;
	endsequence

	sequence softWrite;
		access && hostCmd.write && ctrlHit && hostCmd.byteEn[1]
			&& hostCmd.wdata[ethernet_general_control_pkg::BIT_SOFT_INT];
	endsequence

	a_ack_after_sync: assert property (heldReq |=> hostAck)
		else $error("ack not raised three cycles after request");

	a_ack_release: assert property (
		hostAck && !reqSync2 |=> !hostAck)
		else $error("ack kept after request withdrawn");

	a_reserved_read_zero: assert property (
		$rose(hostAck) |-> hostRdata[31:6] == 26'h0)
		else $error("reserved or high bits read nonzero");

	a_soft_int_pulse: assert property (
		softWrite |=> raiseSoftwareInterrupt ##1 !raiseSoftwareInterrupt)
		else $error("software interrupt not a single pulse");

	a_no_stray_int: assert property (
		!(ctrlWrite && hostCmd.byteEn[1]
			&& hostCmd.wdata[ethernet_general_control_pkg::BIT_SOFT_INT])
		|=> !raiseSoftwareInterrupt)
		else $error("software interrupt without a write of bit 8");

	a_read_back_ctrl: assert property (
		access && !hostCmd.write && ctrlHit |=> hostRdata[5:0] == $past(ctrlState))
		else $error("control read does not match stored bits");

	a_fp_reset_hold: assert property (
		ctrlWrite && hostCmd.byteEn[0] && !hostCmd.wdata[5] |=> txFrameProcessorRst)
		else $error("transmit processor not held after clear");

	a_rx_fp_hold: assert property (!ctrlState.rxFrameProcessorOn |-> rxFrameProcessorRst)
		else $error("receive processor not held");

	a_tx_dma_gate: assert property (!ctrlState.transmitDmaAllow |-> txDmaReq == 3'h0)
		else $error("transmit dma request while disabled");

	a_rx_dma_gate: assert property (!ctrlState.receiveDmaAllow |-> rxDmaReq == 3'h0)
		else $error("receive dma request while disabled");

	a_error_clears_dma: assert property (
		pciMasterError |=> !ctrlState.transmitDmaAllow && !ctrlState.receiveDmaAllow)
		else $error("dma enables survive master error");

	a_index_gate: assert property (
		(txIndexWr |-> !ctrlState.transmitDmaAllow)
		and (rxIndexWr |-> !ctrlState.receiveDmaAllow))
		else $error("queue index write while dma enabled");

	a_tx_engine_gate: assert property (txFrameValid |-> ctrlState.transmitEngineOn)
		else $error("transmit data with engine off");

	a_tx_dma_indep: assert property (ctrlState.transmitDmaAllow |-> txDmaReq == txDmaReqIn)
		else $error("transmit dma blocked by other bits");

	a_rx_drop_frame: assert property (
		rxStart && !ctrlState.receiveEngineOn |->
		!rxFrameValid ##1 rxFrameDropped && (!rxFrameValid || rxStart))
		else $error("frame not dropped with receive engine off");

	a_rx_keeps_frame: assert property (
		rxPassing && rxFrameIn |-> rxFrameValid)
		else $error("admitted frame cut short");

	a_reset_clear: assert property ($past(rst) |-> ctrlState == 6'h00 && !hostAck)
		else $error("control bits not clear after reset");

endmodule

// ===== verification/ethernet_general_control_bench.sv
`timescale 1ns/1ps

module ethernet_general_control_bench;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                                        clk = 1'b0;
	logic                                        rst = 1'b1;
	logic                                        hostReq = 1'b0;
	ethernet_general_control_pkg::host_req_t     hostCmd = '0;
	logic                                        hostAck;
	logic [31:0]                                 hostRdata;
	logic                                        pciMasterError = 1'b0;
	logic                                        raiseSoftwareInterrupt;
	ethernet_general_control_pkg::ctrl_t         ctrlState;
	logic                                        txFrameProcessorRst;
	logic                                        rxFrameProcessorRst;
	logic [2:0]                                  txDmaReqIn = 3'h7;
	logic [2:0]                                  txDmaReq;
	logic [2:0]                                  rxDmaReqIn = 3'h7;
	logic [2:0]                                  rxDmaReq;
	logic                                        txIndexWrIn = 1'b1;
	logic                                        txIndexWr;
	logic                                        rxIndexWrIn = 1'b1;
	logic                                        rxIndexWr;
	logic                                        txFrameValidIn = 1'b1;
	logic                                        txFrameValid;
	logic                                        rxFrameIn = 1'b0;
	logic                                        rxFrameValid;
	logic                                        rxFrameDropped;
	int                                          mismatches = 0;
	int                                          samplesChecked = 0;

	always #4 clk = ~clk; // 125 MHz

	ethernet_general_control u_dut (
		.clk(clk), .rst(rst), .hostReq(hostReq), .hostCmd(hostCmd), .hostAck(hostAck),
		.hostRdata(hostRdata), .pciMasterError(pciMasterError),
		.raiseSoftwareInterrupt(raiseSoftwareInterrupt), .ctrlState(ctrlState),
		.txFrameProcessorRst(txFrameProcessorRst), .rxFrameProcessorRst(rxFrameProcessorRst),
		.txDmaReqIn(txDmaReqIn), .txDmaReq(txDmaReq), .rxDmaReqIn(rxDmaReqIn),
		.rxDmaReq(rxDmaReq), .txIndexWrIn(txIndexWrIn), .txIndexWr(txIndexWr),
		.rxIndexWrIn(rxIndexWrIn), .rxIndexWr(rxIndexWr), .txFrameValidIn(txFrameValidIn),
		.txFrameValid(txFrameValid), .rxFrameIn(rxFrameIn), .rxFrameValid(rxFrameValid),
		.rxFrameDropped(rxFrameDropped)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// one four-phase host access, driven just after an edge
	task automatic access(input int sp, input logic [18:0] a, input logic wr,
			input logic [31:0] wd, input logic expInt, output logic [31:0] rd);
		int n;
		hostCmd.space = ethernet_general_control_pkg::space_t'(sp);
		hostCmd.addr = a;
		hostCmd.write = wr;
		hostCmd.byteEn = 4'hF;
		hostCmd.wdata = wd;
		hostReq = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (hostAck !== 1'b1 && n < 40);
		check(32'(n), 32'h3);
		check({31'h0, raiseSoftwareInterrupt}, {31'h0, expInt});
		rd = hostRdata;
		hostReq = 1'b0;
		n = 0;
		while (hostAck !== 1'b0 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		check({31'h0, hostAck}, 32'h0);
	endtask

	task automatic wr(input int sp, input logic [31:0] wd, input logic expInt);
		logic [31:0] d;
		access(sp, ethernet_general_control_pkg::CTRL_OFFSET, 1'b1, wd, expInt, d);
	endtask

	task automatic rd(input int sp, input logic [18:0] a, input logic [31:0] exp);
		logic [31:0] d;
		access(sp, a, 1'b0, 32'h0, 1'b0, d);
		check(d, exp);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		check({26'h0, ctrlState}, 32'h0);
		check({30'h0, txFrameProcessorRst, rxFrameProcessorRst}, 32'h3);
		for (int s = 0; s < 3; s++)
			rd(s, ethernet_general_control_pkg::CTRL_OFFSET, 32'h0);
		$display("test reset done");
	endtask

	// all ones in every space: reserved bits vanish, interrupt pulses
	task automatic test_access;
		logic [31:0] d;
		for (int s = 0; s < 3; s++) begin
			wr(s, 32'h0, 1'b0);
			wr(s, 32'hFFFF_FFFF, 1'b1);
			rd(s, ethernet_general_control_pkg::CTRL_OFFSET, 32'h0000_003F);
			wr(s, 32'h0000_02C0, 1'b0);
			rd(s, ethernet_general_control_pkg::CTRL_OFFSET, 32'h0);
		end
		wr(1, 32'h0000_0100, 1'b1);
		access(1, 19'h00074, 1'b1, 32'hFFFF_FFFF, 1'b0, d);
		rd(1, ethernet_general_control_pkg::CTRL_OFFSET, 32'h0);
		rd(1, 19'h00074, 32'h0);
		$display("test access done");
	endtask

	// every value of the six control bits against every gate but receive admission, under two raw input sets
	task automatic test_gates;
		logic [5:0] v;
		logic       on;
		logic [2:0] raw;
		for (int i = 0; i < 128; i++) begin
			v = 6'(i);
			on = ~i[6];
			raw = {on, ~on, on};
			txDmaReqIn = raw;
			rxDmaReqIn = ~raw;
			txIndexWrIn = on;
			rxIndexWrIn = ~on;
			txFrameValidIn = on;
			wr(1, {26'h0, v}, 1'b0);
			check({26'h0, ctrlState}, {26'h0, v});
			check({31'h0, txFrameProcessorRst}, {31'h0, ~v[5]});
			check({31'h0, rxFrameProcessorRst}, {31'h0, ~v[4]});
			check({29'h0, txDmaReq}, {29'h0, raw & {3{v[3]}}});
			check({29'h0, rxDmaReq}, {29'h0, ~raw & {3{v[2]}}});
			check({31'h0, txIndexWr}, {31'h0, on & ~v[3]});
			check({31'h0, rxIndexWr}, {31'h0, ~on & ~v[2]});
			check({31'h0, txFrameValid}, {31'h0, on & v[1]});
		end
		$display("test gates done");
	endtask

	task automatic test_error;
		wr(0, 32'h0000_003F, 1'b0);
		pciMasterError = 1'b1;
		@(posedge clk);
		#1;
		pciMasterError = 1'b0;
		check({26'h0, ctrlState}, 32'h0000_0033);
		@(posedge clk);
		#1;
		pciMasterError = 1'b1;
		wr(0, 32'h0000_003F, 1'b0);
		pciMasterError = 1'b0;
		check({26'h0, ctrlState}, 32'h0000_0033);
		$display("test error done");
	endtask

	// one admitted frame, then one dropped frame
	task automatic test_receive;
		for (int e = 1; e >= 0; e--) begin
			wr(2, {31'h0, 1'(e)}, 1'b0);
			rxFrameIn = 1'b1;
			@(posedge clk);
			#1;
			check({31'h0, rxFrameDropped}, {31'h0, ~1'(e)});
			check({31'h0, rxFrameValid}, {31'h0, 1'(e)});
			@(posedge clk);
			#1;
			check({31'h0, rxFrameDropped}, 32'h0);
			rxFrameIn = 1'b0;
			@(posedge clk);
			#1;
		end
		$display("test receive done");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog: about thirteen times the expected run
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#1;
		test_reset();
		test_access();
		test_gates();
		test_error();
		test_receive();
		wrap_up();
	end

endmodule
